// file: hw/afl_alert_drv.sv
// Open-collector alert pin driver with selectable sense.
// Assumes an external pull-up; the pin is only ever pulled low or released.
`default_nettype none

module afl_alert_drv (
	// Clock and reset
	input  wire logic clk,
	input  wire logic reset_n,
	// Alert request
	input  wire logic alert_active,
	input  wire logic alert_pol,
	// Pin
	output logic      pin_o,
	output logic      pin_oe
);
	typedef struct packed {
		logic oe;
	} afl_drv_state_t;

	afl_drv_state_t st_r;
	afl_drv_state_t st_nxt;

	// Normal sense pulls low while active; inverted pulls low while idle
	always_comb begin
		st_nxt    = st_r;
		st_nxt.oe = alert_active ^ alert_pol;
	end

	// Released pin after reset: idle and normal sense
	always_ff @(posedge clk) begin
		if (!reset_n)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign pin_o  = 1'b0;
	assign pin_oe = st_r.oe;

	normal_sense_a: assert property (@(posedge clk) disable iff (!reset_n)
		!alert_pol |=> (pin_oe == $past(alert_active)))
		else $error("alert pin wrong in normal sense");
	inverted_sense_a: assert property (@(posedge clk) disable iff (!reset_n)
		alert_pol && alert_active |=> !pin_oe)
		else $error("alert pin pulled low while active in inverted sense");

endmodule

`default_nettype wire

// file: hw/afl_cmp_if.sv
// Interface between the flag logic and the limit comparator.
// Assumes both ends sit in one clock domain; the comparator is combinational.
`default_nettype none

interface afl_cmp_if;
	logic [5:0]  sel;
	logic [15:0] shunt;
	logic [15:0] bus;
	logic [15:0] power;
	logic [15:0] limit;
	logic        exceed;

	modport ctl (output sel, output shunt, output bus, output power, output limit,
		input exceed);
	modport cmp (input sel, input shunt, input bus, input power, input limit,
		output exceed);
endinterface

`default_nettype wire

// file: hw/afl_flag_top.sv
// Alert flag and latch logic of a current, voltage and power monitor.
// Assumes a 16-bit register port driven by the serial bus logic and a
// conversion engine that pulses conv_done when a result set is final.
`default_nettype none

// Function
// - Transparent mode clears alert flag after a conversion without alert.
// - Conversion ready flag, bit 3, sets when conversion, averaging, multiply finish.
// - Single-shot config write clears ready flag unless power-down selected.
// - Single-shot read of select/flags register clears ready flag.
// - Math overflow flag, bit 2, sets on arithmetic overflow.
// - Polarity bit 1: one inverted active-high, zero normal active-low default.
// - Transparent mode returns pin and flags idle once fault is gone.
// - Latched mode holds pin and flags until select/flags register read.
// - Selected measurement is compared against the alert threshold.
// - Alert threshold is 16-bit read/write, resets to zero.
// - Result registers always readable with latest completed conversion.
module afl_flag_top (
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                reset_n,
	// Register port
	input  wire logic [7:0]          reg_addr,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	input  wire logic [15:0]         reg_wdata,
	output logic      [15:0]         reg_rdata,
	// Conversion engine
	input  wire logic                conv_done,
	input  wire logic [15:0]         conv_shunt,
	input  wire logic [15:0]         conv_bus,
	input  wire logic [15:0]         conv_power,
	input  wire logic [15:0]         conv_current,
	input  wire logic                conv_math_ovf,
	output logic      [15:0]         cfg_value,
	// Alert pin, open collector
	input  wire logic                alert_pin_i,
	output logic                     alert_pin_o,
	output logic                     alert_pin_oe
);
	import afl_pkg::*;

	typedef struct packed {
		logic [15:0]                  cfg;
		logic [5:0]                   sel;
		logic                         pol;
		logic                         latch;
		logic                         alert_flag;
		logic                         ready;
		logic                         overflow;
		logic                         pin_s1;
		logic                         pin_s2;
		logic [15:0]                  limit;
		logic [AFL_NUM_RES-1:0][15:0] res;
		logic [15:0]                  rdata;
	} afl_state_t;

	afl_state_t st_r;
	afl_state_t st_nxt;

	logic        wr_cfg;
	logic        wr_mask;
	logic        wr_limit;
	logic        rd_mask;
	logic        single_shot;
	logic        alert_active;
	logic [15:0] mask_view;
	logic [1:0]  res_idx;

	afl_cmp_if cif ();

	// Access decode of the register port
	assign wr_cfg   = reg_wr && (reg_addr == AFL_OFS_CONFIG);
	assign wr_mask  = reg_wr && (reg_addr == AFL_OFS_MASK);
	assign wr_limit = reg_wr && (reg_addr == AFL_OFS_LIMIT);
	assign rd_mask  = reg_rd && (reg_addr == AFL_OFS_MASK);
	assign res_idx  = 2'(reg_addr - AFL_OFS_SHUNT);

	assign single_shot = afl_is_single_shot(st_r.cfg[AFL_MODE_MSB:AFL_MODE_LSB]);

	// Select/flags register as software sees it; unused bits read zero
	always_comb begin
		mask_view                          = 16'h0000;
		mask_view[AFL_SEL_MSB:AFL_SEL_LSB] = st_r.sel;
		mask_view[AFL_BIT_ALERT]           = st_r.alert_flag;
		mask_view[AFL_BIT_READY]           = st_r.ready;
		mask_view[AFL_BIT_OVERFLOW]        = st_r.overflow;
		mask_view[AFL_BIT_POL]             = st_r.pol;
		mask_view[AFL_BIT_LATCH]           = st_r.latch;
	end

	// Comparator sees the fresh conversion results, not the stored ones,
	// so the flag decided at conv_done matches the data that gets stored
	assign cif.sel   = st_r.sel;
	assign cif.shunt = conv_shunt;
	assign cif.bus   = conv_bus;
	assign cif.power = conv_power;
	assign cif.limit = st_r.limit;

	afl_limit_cmp u_cmp (
		.cif (cif.cmp)
	);

	// Next state: writes, read side effects, then conversion events.
	// Conversion events come last so a set beats a clear in the same cycle.
	always_comb begin
		st_nxt = st_r;
		if (wr_cfg)
			st_nxt.cfg = reg_wdata;
		if (wr_mask) begin
			st_nxt.sel = reg_wdata[AFL_SEL_MSB:AFL_SEL_LSB];
			st_nxt.pol = reg_wdata[AFL_BIT_POL];
			st_nxt.latch = reg_wdata[AFL_BIT_LATCH];
		end
		if (wr_limit)
			st_nxt.limit = reg_wdata;
		// Ready flag clears only while single-shot is in force
		if (single_shot && wr_cfg &&
			!afl_is_power_down(reg_wdata[AFL_MODE_MSB:AFL_MODE_LSB]))
			st_nxt.ready = 1'b0;
		if (single_shot && rd_mask)
			st_nxt.ready = 1'b0;
		// Reading the select/flags register releases latched flags, unless conv_done comes in the same cycle and keeps the old flags
		if (st_r.latch && rd_mask) begin
			st_nxt.alert_flag = 1'b0;
			st_nxt.overflow   = 1'b0;
		end
		if (conv_done) begin
			st_nxt.res[AFL_RES_SHUNT]   = conv_shunt;
			st_nxt.res[AFL_RES_BUS]     = conv_bus;
			st_nxt.res[AFL_RES_POWER]   = conv_power;
			st_nxt.res[AFL_RES_CURRENT] = conv_current;
			st_nxt.ready                = 1'b1;
			if (st_r.latch) begin
				// Latched: accumulate until software reads
				st_nxt.alert_flag = st_r.alert_flag | cif.exceed;
				st_nxt.overflow   = st_r.overflow | conv_math_ovf;
			end else begin
				// Transparent: each conversion decides afresh
				st_nxt.alert_flag = cif.exceed;
				st_nxt.overflow   = conv_math_ovf;
			end
		end
		// Pin level comes from outside the clock domain: two flops first
		st_nxt.pin_s1 = alert_pin_i;
		st_nxt.pin_s2 = st_r.pin_s1;
		// Read data is captured before this cycle's clears take effect
		if (reg_rd) begin
			case (reg_addr)
				AFL_OFS_CONFIG:
					st_nxt.rdata = st_r.cfg;
				AFL_OFS_SHUNT, AFL_OFS_BUS, AFL_OFS_POWER, AFL_OFS_CURRENT:
					st_nxt.rdata = st_r.res[res_idx];
				AFL_OFS_MASK:
					st_nxt.rdata = mask_view;
				AFL_OFS_LIMIT:
					st_nxt.rdata = st_r.limit;
				default:
					st_nxt.rdata = 16'h0000;
			endcase
		end
	end

	// State register with synchronous reset
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			st_r       <= '0;
			st_r.cfg   <= AFL_CONFIG_RESET;
			st_r.sel   <= AFL_SEL_RESET;
			st_r.limit <= AFL_LIMIT_RESET;
			st_r.res   <= {AFL_NUM_RES{AFL_RES_RESET}};
			// Released line idles high through its pull-up
			st_r.pin_s1 <= AFL_PIN_IDLE;
			st_r.pin_s2 <= AFL_PIN_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Pin follows the flags in both modes; latching lives in the flags
	assign alert_active = st_r.alert_flag ||
		(st_r.sel[AFL_SEL_CONV_READY] && st_r.ready);

	afl_alert_drv u_drv (
		.clk          (clk),
		.reset_n      (reset_n),
		.alert_active (alert_active),
		.alert_pol    (st_r.pol),
		.pin_o        (alert_pin_o),
		.pin_oe       (alert_pin_oe)
	);

	assign reg_rdata = st_r.rdata;
	assign cfg_value = st_r.cfg;

	// Checks on the flag logic
	default clocking afl_cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	// Ready flag: set by conversions, cleared by single-shot accesses
	ready_set_a: assert property (conv_done |=> st_r.ready)
		else $error("ready flag not set after conversion");

	cfg_wr_clear_a: assert property (
		single_shot && wr_cfg && !conv_done &&
		!afl_is_power_down(reg_wdata[AFL_MODE_MSB:AFL_MODE_LSB]) |=> !st_r.ready)
		else $error("ready flag kept after config write");

	cfg_pd_keep_a: assert property (
		st_r.ready && wr_cfg && !rd_mask &&
		afl_is_power_down(reg_wdata[AFL_MODE_MSB:AFL_MODE_LSB]) |=> st_r.ready)
		else $error("ready flag cleared by power-down write");

	// Continuous modes never clear the ready flag
	ready_keep_a: assert property (
		!single_shot && st_r.ready |=> st_r.ready)
		else $error("ready flag cleared outside single-shot");

	mask_rd_clear_a: assert property (
		single_shot && rd_mask && !conv_done |=> !st_r.ready)
		else $error("ready flag kept after flags read");

	// Read data of the flags register is the pre-clear view
	mask_rdata_a: assert property (rd_mask |=> reg_rdata == $past(mask_view))
		else $error("flags read data wrong");

	cfg_write_a: assert property (wr_cfg |=> cfg_value == $past(reg_wdata))
		else $error("config write lost");

	// Overflow flag
	ovf_set_a: assert property (conv_done && conv_math_ovf |=> st_r.overflow)
		else $error("overflow flag not set");

	ovf_transp_a: assert property (
		!st_r.latch && conv_done && !conv_math_ovf |=> !st_r.overflow)
		else $error("overflow flag kept in transparent mode");

	// Alert flag in transparent and latched operation
	transp_clear_a: assert property (
		!st_r.latch && !wr_mask && conv_done && !cif.exceed |=> !st_r.alert_flag)
		else $error("alert flag kept in transparent mode");

	latch_set_a: assert property (
		st_r.latch && conv_done && cif.exceed |=> st_r.alert_flag)
		else $error("latched alert flag not set");

	latch_hold_a: assert property (
		st_r.latch && st_r.alert_flag && !rd_mask && !wr_mask |=> st_r.alert_flag)
		else $error("latched alert flag dropped without read");

	latch_rd_release_a: assert property (
		st_r.latch && rd_mask && !conv_done && !wr_mask |=>
		!st_r.alert_flag && !st_r.overflow)
		else $error("latched flags kept after read");

	eval_once_a: assert property (
		!conv_done |=> $stable(st_r.alert_flag) || $past(st_r.latch && rd_mask))
		else $error("alert flag moved between conversions");

	// Writes to the flags register leave the read-only flags alone
	flags_ro_a: assert property (
		wr_mask && !conv_done |=> $stable(st_r.alert_flag) && $stable(st_r.overflow))
		else $error("flag changed by register write");

	// Pin goes idle in the cycle after the alert condition is gone
	pin_idle_a: assert property (!alert_active |=> alert_pin_oe == $past(st_r.pol))
		else $error("alert pin not idle");

	// Selection, threshold and results
	sel_write_a: assert property (
		wr_mask |=> st_r.sel == $past(reg_wdata[AFL_SEL_MSB:AFL_SEL_LSB]))
		else $error("selection write lost");

	limit_hold_a: assert property (!wr_limit |=> $stable(st_r.limit))
		else $error("threshold changed without write");

	limit_rst_a: assert property ($rose(reset_n) |-> st_r.limit == 16'h0000)
		else $error("threshold not zero after reset");
	limit_rw_a: assert property (
		wr_limit ##1 (reg_rd && reg_addr == AFL_OFS_LIMIT && !reg_wr) |=>
		reg_rdata == $past(reg_wdata, 2))
		else $error("threshold read back wrong");
	res_hold_a: assert property (!conv_done |=> $stable(st_r.res))
		else $error("results changed without conversion");
	res_read_a: assert property (
		conv_done ##1 (reg_rd && reg_addr == AFL_OFS_BUS && !conv_done) |=>
		reg_rdata == $past(conv_bus, 2))
		else $error("bus result read back wrong");


	// Main scenarios
	latched_alert_c: cover property (st_r.latch && conv_done && cif.exceed ##[1:20] rd_mask);
	transp_release_c: cover property (!st_r.latch && st_r.alert_flag ##[1:20] !st_r.alert_flag);
	ready_alert_c: cover property (st_r.sel[AFL_SEL_CONV_READY] && st_r.ready && st_r.pol);
	overflow_c: cover property (conv_done && conv_math_ovf && cif.exceed);
	pin_seen_low_c: cover property (alert_pin_oe ##3 !st_r.pin_s2);

endmodule

`default_nettype wire

// file: hw/afl_limit_cmp.sv
// Limit comparator: picks the highest enabled measurement function and
// compares it with the limit. Assumes measurements valid when sampled.
`default_nettype none

module afl_limit_cmp (
	// Comparator side of the carrier
	afl_cmp_if.cmp cif
);
	import afl_pkg::*;

	logic shunt_gt;
	logic shunt_lt;

	// Shunt reading is two's complement, so its compare is signed
	assign shunt_gt = $signed(cif.shunt) > $signed(cif.limit);
	assign shunt_lt = $signed(cif.shunt) < $signed(cif.limit);

	// Highest selected bit wins; conversion-ready raises no limit event
	always_comb begin
		if (cif.sel[AFL_SEL_SHUNT_OVER])
			cif.exceed = shunt_gt;
		else if (cif.sel[AFL_SEL_SHUNT_UNDER])
			cif.exceed = shunt_lt;
		else if (cif.sel[AFL_SEL_BUS_OVER])
			cif.exceed = cif.bus > cif.limit;
		else if (cif.sel[AFL_SEL_BUS_UNDER])
			cif.exceed = cif.bus < cif.limit;
		else if (cif.sel[AFL_SEL_POWER_OVER])
			cif.exceed = cif.power > cif.limit;
		else
			cif.exceed = 1'b0;
	end

endmodule

`default_nettype wire

// file: hw/afl_pkg.sv
// Package of the alert flag and latch logic: register offsets, field
// positions, reset values and the operating-mode decode.
// Assumes a 16-bit register port and a conversion engine on the same clock.
`default_nettype none

package afl_pkg;

	// Register offsets on the register port
	localparam logic [7:0] AFL_OFS_CONFIG  = 8'h00;
	localparam logic [7:0] AFL_OFS_SHUNT   = 8'h01;
	localparam logic [7:0] AFL_OFS_BUS     = 8'h02;
	localparam logic [7:0] AFL_OFS_POWER   = 8'h03;
	localparam logic [7:0] AFL_OFS_CURRENT = 8'h04;
	localparam logic [7:0] AFL_OFS_MASK    = 8'h06;
	localparam logic [7:0] AFL_OFS_LIMIT   = 8'h07;

	// Result storage, indexed by offset minus the first result offset
	localparam int         AFL_NUM_RES     = 4;
	localparam logic [1:0] AFL_RES_SHUNT   = 2'h0;
	localparam logic [1:0] AFL_RES_BUS     = 2'h1;
	localparam logic [1:0] AFL_RES_POWER   = 2'h2;
	localparam logic [1:0] AFL_RES_CURRENT = 2'h3;

	// Field positions in the alert select and flags register
	localparam int AFL_SEL_MSB  = 15;
	localparam int AFL_SEL_LSB  = 10;
	localparam int AFL_BIT_ALERT    = 4;
	localparam int AFL_BIT_READY    = 3;
	localparam int AFL_BIT_OVERFLOW = 2;
	localparam int AFL_BIT_POL      = 1;
	localparam int AFL_BIT_LATCH    = 0;

	// Positions within the 6-bit selection field
	localparam int AFL_SEL_SHUNT_OVER  = 5;
	localparam int AFL_SEL_SHUNT_UNDER = 4;
	localparam int AFL_SEL_BUS_OVER    = 3;
	localparam int AFL_SEL_BUS_UNDER   = 2;
	localparam int AFL_SEL_POWER_OVER  = 1;
	localparam int AFL_SEL_CONV_READY  = 0;

	// Reset values
	localparam logic [15:0] AFL_CONFIG_RESET = 16'h0000;
	localparam logic [15:0] AFL_LIMIT_RESET  = 16'h0000;
	localparam logic [5:0]  AFL_SEL_RESET    = 6'h00;
	localparam logic [15:0] AFL_RES_RESET    = 16'h0000;
	localparam logic        AFL_PIN_IDLE     = 1'b1;

	// Operating-mode field of the configuration register
	localparam int         AFL_MODE_MSB     = 2;
	localparam int         AFL_MODE_LSB     = 0;
	localparam logic [2:0] AFL_MODE_PD0     = 3'h0;
	localparam logic [2:0] AFL_MODE_PD1     = 3'h4;
	localparam logic [2:0] AFL_MODE_SS_HIGH = 3'h3;

	// Single-shot modes are the non-zero codes up to the highest single-shot code
	function automatic logic afl_is_single_shot(input logic [2:0] mode);
		afl_is_single_shot = (mode != AFL_MODE_PD0) && (mode <= AFL_MODE_SS_HIGH);
	endfunction

	// Power-down or disable selections
	function automatic logic afl_is_power_down(input logic [2:0] mode);
		afl_is_power_down = (mode == AFL_MODE_PD0) || (mode == AFL_MODE_PD1);
	endfunction

endpackage

`default_nettype wire

// file: tb/afl_host_model.sv
// Host model: register port master and the pull-up on the alert line.
// Assumes the device samples its strobes on the rising clock edge.
`default_nettype none

module afl_host_model (
	// Clock
	input  wire logic        clk,
	// Register port
	output logic      [7:0]  reg_addr,
	output logic             reg_wr,
	output logic             reg_rd,
	output logic      [15:0] reg_wdata,
	input  wire logic [15:0] reg_rdata,
	// Alert pin
	input  wire logic        pin_o,
	input  wire logic        pin_oe,
	output logic             alert_line
);
	timeunit 1ns;
	timeprecision 1ps;

	// Pull-up wins unless the device sinks the line
	assign alert_line = (pin_oe && !pin_o) ? 1'b0 : 1'b1;

	// Idle bus at time zero
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 16'h0000;
	end

	// One write strobe; data turned over after so stale data never counts
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
		reg_wdata = ~d;
	endtask

	// One read strobe; data taken a cycle later, a read of the flags register releases latches
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		d = reg_rdata;
	endtask
endmodule

`default_nettype wire

// file: tb/alert_flag_latch_logic_tb.sv
// Bench of the alert flag and latch logic: table of alert cases, then
// latched, single-shot, refusal and reset tests. Uses afl_host_model.
`default_nettype none

module alert_flag_latch_logic_tb import afl_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		logic [15:0] m, l, s, b, p;
		logic        o, f, e;
	} afl_row_t;

	logic        clk, reset_n, reg_wr, reg_rd, alert_line, alert_pin_o, alert_pin_oe;
	logic [7:0]  reg_addr;
	logic [15:0] reg_wdata, reg_rdata, cfg_value, ex;
	logic        conv_done, conv_math_ovf;
	logic [15:0] conv_shunt, conv_bus, conv_power, conv_current;
	int          n_mismatch, compares, cycles;

	// Mask, limit, shunt, bus, power, overflow, expected flag, expected sink
	afl_row_t rows [9] = '{
		'{16'h8000, 16'h00ff, 16'h0100, 16'h0000, 16'h0000, 1'b0, 1'b1, 1'b1},
		'{16'h8000, 16'h00ff, 16'h00ff, 16'h0000, 16'h0000, 1'b0, 1'b0, 1'b0},
		'{16'h4000, 16'h0020, 16'h0010, 16'h0000, 16'h0000, 1'b1, 1'b1, 1'b1},
		'{16'h2000, 16'h8000, 16'h0000, 16'h9000, 16'h0000, 1'b0, 1'b1, 1'b1},
		'{16'h1000, 16'h8000, 16'h0000, 16'h9000, 16'h0000, 1'b0, 1'b0, 1'b0},
		'{16'h0802, 16'h1233, 16'h0000, 16'h0000, 16'h1234, 1'b0, 1'b1, 1'b0},
		'{16'h8002, 16'h0010, 16'hff00, 16'h0000, 16'h0000, 1'b0, 1'b0, 1'b1},
		'{16'ha000, 16'h0100, 16'h0000, 16'h0200, 16'h0000, 1'b0, 1'b0, 1'b0},
		'{16'h0400, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 1'b0, 1'b0, 1'b1}};

	afl_host_model i_host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.pin_o(alert_pin_o), .pin_oe(alert_pin_oe), .alert_line(alert_line));

	afl_flag_top i_dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.conv_done(conv_done), .conv_shunt(conv_shunt), .conv_bus(conv_bus),
		.conv_power(conv_power), .conv_current(conv_current),
		.conv_math_ovf(conv_math_ovf), .cfg_value(cfg_value), .alert_pin_i(alert_line),
		.alert_pin_o(alert_pin_o), .alert_pin_oe(alert_pin_oe));

	// 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Hang guard, well above the fewer than two hundred cycles the tests need
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			conclude();
		end
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic rdc(input logic [7:0] a, input logic [15:0] e);
		logic [15:0] d;
		i_host.rd(a, d);
		chk(d, e);
	endtask

	task automatic pin(input logic v);
		chk({15'h0, alert_line}, {15'h0, v});
	endtask

	// One conversion pulse; results turned over after so late sampling shows
	task automatic conv(input logic [15:0] s, b, p, input logic o);
		@(negedge clk);
		{conv_shunt, conv_bus, conv_power, conv_current} = {s, b, p, s ^ b};
		conv_math_ovf = o;
		conv_done = 1'b1;
		@(negedge clk);
		conv_done = 1'b0;
		{conv_shunt, conv_bus, conv_power, conv_current} = ~{s, b, p, s ^ b};
		conv_math_ovf = ~o;
	endtask

	initial begin
		reset_n = 1'b0;
		conv_done = 1'b0;
		conv_math_ovf = 1'b0;
		{conv_shunt, conv_bus, conv_power, conv_current} = 64'h0;
		repeat (12) @(negedge clk);
		reset_n = 1'b1;
		// Table of transparent alert cases
		foreach (rows[i]) begin
			i_host.wr(AFL_OFS_LIMIT, rows[i].l);
			i_host.wr(AFL_OFS_MASK, rows[i].m);
			conv(rows[i].s, rows[i].b, rows[i].p, rows[i].o);
			@(negedge clk);
			pin(!rows[i].e);
			ex = rows[i].m;
			ex[4] = rows[i].f;
			ex[3] = 1'b1;
			ex[2] = rows[i].o;
			rdc(AFL_OFS_MASK, ex);
		end
		// Limit change between conversions waits for the next conversion
		i_host.wr(AFL_OFS_LIMIT, 16'h0100);
		i_host.wr(AFL_OFS_MASK, 16'h8000);
		conv(16'h0200, 16'h0, 16'h0, 1'b0);
		// Shunt compare is signed, so the largest positive threshold
		i_host.wr(AFL_OFS_LIMIT, 16'h7fff);
		rdc(AFL_OFS_MASK, 16'h8018);
		conv(16'h0200, 16'h0, 16'h0, 1'b0);
		rdc(AFL_OFS_MASK, 16'h8008);
		// Latched: fault then clean conversion, only the read releases
		i_host.wr(AFL_OFS_LIMIT, 16'h0100);
		i_host.wr(AFL_OFS_MASK, 16'h8001);
		conv(16'h0200, 16'h0, 16'h0, 1'b1);
		conv(16'h0000, 16'h0, 16'h0, 1'b0);
		@(negedge clk);
		pin(1'b0);
		rdc(AFL_OFS_MASK, 16'h801d);
		rdc(AFL_OFS_MASK, 16'h8009);
		pin(1'b1);
		// Single-shot ready flag, watched on the pin through bit 10
		i_host.wr(AFL_OFS_MASK, 16'h0400);
		i_host.wr(AFL_OFS_CONFIG, 16'h0001);
		chk(cfg_value, 16'h0001);
		conv(16'h1111, 16'h2222, 16'h3333, 1'b0);
		rdc(8'h01, 16'h1111);
		rdc(8'h02, 16'h2222);
		rdc(8'h03, 16'h3333);
		rdc(8'h04, 16'h3333);
		rdc(AFL_OFS_MASK, 16'h0408);
		rdc(AFL_OFS_MASK, 16'h0400);
		pin(1'b1);
		rdc(8'h01, 16'h1111);
		conv(16'h1111, 16'h2222, 16'h3333, 1'b0);
		i_host.wr(AFL_OFS_CONFIG, 16'h0004);
		@(negedge clk);
		pin(1'b0);
		i_host.wr(AFL_OFS_CONFIG, 16'h0001);
		i_host.wr(AFL_OFS_CONFIG, 16'h0002);
		@(negedge clk);
		pin(1'b1);
		// Refused writes and unmapped read
		i_host.wr(8'h01, 16'habcd);
		rdc(8'h01, 16'h1111);
		rdc(8'h05, 16'h0000);
		i_host.wr(AFL_OFS_MASK, 16'h03fc);
		rdc(AFL_OFS_MASK, 16'h0000);
		// Threshold is read/write, then a reset in mid-run
		i_host.wr(AFL_OFS_LIMIT, 16'ha5c3);
		rdc(AFL_OFS_LIMIT, 16'ha5c3);
		i_host.wr(AFL_OFS_MASK, 16'h0003);
		@(negedge clk);
		reset_n = 1'b0;
		repeat (2) @(negedge clk);
		reset_n = 1'b1;
		chk(cfg_value, 16'h0000);
		pin(1'b1);
		rdc(AFL_OFS_LIMIT, 16'h0000);
		rdc(AFL_OFS_MASK, 16'h0000);
		conclude();
	end
endmodule

`default_nettype wire
